// ==== hw/gpc_gpio_top.sv ====
// Functional notes
// (RULE1) eleven pins: input, output or alternate
// (RULE2) pin six has no alternate function
// (RULE3) pins 8,0,9,1,10 drive downstream resets 1-5
// (RULE4) pins 2-5 carry expander interrupts 0-3
// (RULE5) pin seven drives the event output
// (RULE6) reset: all pins general purpose inputs
// (RULE7) inputs synchronised, sampled at most every 128ns
// (RULE8) unused alternate signals held inactive
// (RULE9) one bit per pin, same position everywhere
// (RULE10) function bit selects alternate, else direction decides
// (RULE11) input mode captures pin into data bit
// (RULE12) data reads return real pin levels
// (RULE13) output mode drives stored data bit
// (RULE14) registers reached by configuration accesses
// (RULE15) upper bits read zero; output value retained
`timescale 1ns/1ns
`include "gpc_defs.svh"

module gpc_gpio_top #(
    parameter int N = `GPC_NUM_PINS,
    parameter int SAMPLE_CYC = `GPC_SAMPLE_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire gpc_pkg::gpc_cfg_req_t cfg_req_in,
    output gpc_pkg::gpc_cfg_rsp_t cfg_rsp_out,
    input wire logic [N-1:0] gpio_pin_in,
    output logic [N-1:0] gpio_pin_out,
    output logic [N-1:0] gpio_pin_oe_out,
    input wire logic downstream1_reset_n_in,
    input wire logic downstream2_reset_n_in,
    input wire logic downstream3_reset_n_in,
    input wire logic downstream4_reset_n_in,
    input wire logic downstream5_reset_n_in,
    input wire logic general_event_n_in,
    output logic [3:0] expander_irq_n_out
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    // the alternate function map is fixed to eleven pins
    if (N != `GPC_NUM_PINS) begin : g_bad_n
        $error("gpc_gpio_top: N must equal the fixed pin count of the alternate map");
    end
    // a shorter interval would let the data register follow the pins too closely
    if (SAMPLE_CYC < `GPC_SAMPLE_CYC) begin : g_bad_cyc // (RULE7)
        $error("gpc_gpio_top: SAMPLE_CYC is below the minimum sample interval");
    end
    // the role masks must split the capable pins into drivers and receivers
    if ((`GPC_ALT_OUTPUT_MASK & `GPC_ALT_INPUT_MASK) != 11'h000) begin : g_bad_roles
        $error("gpc_gpio_top: a pin cannot be both alternate output and input");
    end
    if ((`GPC_ALT_OUTPUT_MASK | `GPC_ALT_INPUT_MASK) != `GPC_ALT_CAPABLE_MASK) begin : g_bad_cover
        $error("gpc_gpio_top: every alternate capable pin needs a role");
    end

    // ****************************************************************
    // pin registers
    // ****************************************************************
    logic [N-1:0] func_q;
    logic [N-1:0] dir_q;
    logic [N-1:0] out_data_q;
    logic [N-1:0] level_sync;
    logic [N-1:0] level_sampled;

    wire [N-1:0] alt_capable = N'(`GPC_ALT_CAPABLE_MASK);
    wire [N-1:0] alt_drives = N'(`GPC_ALT_OUTPUT_MASK);
    wire [N-1:0] wdata_pins = cfg_req_in.wdata[N-1:0];
    // the fourth selector matches none of these: writes drop, reads give zero
    wire sel_func = (cfg_req_in.sel == `GPC_SEL_FUNCTION);
    wire sel_dir = (cfg_req_in.sel == `GPC_SEL_DIRECTION);
    wire sel_data = (cfg_req_in.sel == `GPC_SEL_DATA);
    wire wr_func = cfg_req_in.wr && sel_func;
    wire wr_dir = cfg_req_in.wr && sel_dir;
    wire wr_data = cfg_req_in.wr && sel_data;

    // pin six cannot leave the general purpose function
    wire [N-1:0] func_d = wdata_pins & alt_capable; // (RULE2)

    // bits above the pin field are dropped on write
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            func_q <= N'(`GPC_FUNC_RESET); // (RULE6)
        end else if (wr_func) begin
            func_q <= func_d; // (RULE14)
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_q <= N'(`GPC_DIR_RESET); // (RULE6)
        end else if (wr_dir) begin
            dir_q <= wdata_pins; // (RULE9)
        end
    end

    // kept whatever the mode, so output mode starts from it
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_data_q <= N'(`GPC_OUT_RESET);
        end else if (wr_data) begin
            out_data_q <= wdata_pins; // (RULE15)
        end
    end

    // ****************************************************************
    // pin input sampling
    // ****************************************************************
    gpc_in_sampler #(
        .N(N),
        .SAMPLE_CYC(SAMPLE_CYC)
    ) u_sampler (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in(gpio_pin_in),
        .level_sync_out(level_sync),
        .level_sampled_out(level_sampled) // (RULE11)
    );

    // ****************************************************************
    // alternate function sources
    // ****************************************************************
    logic [N-1:0] alt_val;

    always_comb begin
        alt_val = '1;
        alt_val[`GPC_PIN_DS1_RESET] = downstream1_reset_n_in; // (RULE3)
        alt_val[`GPC_PIN_DS2_RESET] = downstream2_reset_n_in; // (RULE3)
        alt_val[`GPC_PIN_DS3_RESET] = downstream3_reset_n_in; // (RULE3)
        alt_val[`GPC_PIN_DS4_RESET] = downstream4_reset_n_in; // (RULE3)
        alt_val[`GPC_PIN_DS5_RESET] = downstream5_reset_n_in; // (RULE3)
        alt_val[`GPC_PIN_EVENT] = general_event_n_in; // (RULE5)
    end

    // ****************************************************************
    // per pin drivers
    // ****************************************************************
    for (genvar i = 0; i < N; i++) begin : g_pin
        gpc_pin_cell u_cell (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .func_in(func_q[i]), // (RULE1)
            .dir_in(dir_q[i]),
            .out_val_in(out_data_q[i]),
            .alt_val_in(alt_val[i]),
            .alt_drives_in(alt_drives[i]),
            .pin_out(gpio_pin_out[i]),
            .pin_oe_out(gpio_pin_oe_out[i])
        );
    end

    // ****************************************************************
    // expander interrupts toward the core
    // ****************************************************************
    // outside alternate mode the core sees a quiet, high interrupt
    logic [3:0] irq_n_q;
    wire [3:0] irq_alt = func_q[`GPC_PIN_EXP_IRQ0 +: 4];
    wire [3:0] irq_n_d = ~irq_alt | level_sync[`GPC_PIN_EXP_IRQ0 +: 4]; // (RULE4) (RULE8)

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_n_q <= 4'hF;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    assign expander_irq_n_out = irq_n_q;

    // ****************************************************************
    // configuration read path
    // ****************************************************************
    // zero-extended views of the three registers
    wire [31:0] word_func = 32'(func_q);
    wire [31:0] word_dir = 32'(dir_q);
    // real pin level in every mode, not the stored output value
    wire [31:0] word_data = 32'(level_sampled); // (RULE12) (RULE15)
    wire [31:0] rdata_d = sel_func ? word_func :
                          sel_dir ? word_dir :
                          sel_data ? word_data : 32'h0000_0000;
    // data stays zero between answers so a stale word is never taken for a fresh one
    wire [31:0] rsp_rdata_d = cfg_req_in.rd ? rdata_d : 32'h0000_0000;
    logic rsp_valid_q;
    logic [31:0] rsp_rdata_q;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= cfg_req_in.rd;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_rdata_q <= 32'h0000_0000;
        end else begin
            rsp_rdata_q <= rsp_rdata_d; // (RULE14)
        end
    end

    assign cfg_rsp_out = '{valid: rsp_valid_q, rdata: rsp_rdata_q};

endmodule // gpc_gpio_top

// ==== inc/gpc_defs.svh ====
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// ********************************************************************
// pin counts and masks
// ********************************************************************
`define GPC_NUM_PINS 11
`define GPC_ALT_CAPABLE_MASK 11'h7BF
`define GPC_ALT_OUTPUT_MASK 11'h783
`define GPC_ALT_INPUT_MASK 11'h03C

// ********************************************************************
// alternate function pin positions
// ********************************************************************
`define GPC_PIN_DS1_RESET 8
`define GPC_PIN_DS2_RESET 0
`define GPC_PIN_DS3_RESET 9
`define GPC_PIN_DS4_RESET 1
`define GPC_PIN_DS5_RESET 10
`define GPC_PIN_EXP_IRQ0 2
`define GPC_PIN_EVENT 7

// ********************************************************************
// register selectors on the configuration access port
// ********************************************************************
`define GPC_SEL_FUNCTION 2'h0
`define GPC_SEL_DIRECTION 2'h1
`define GPC_SEL_DATA 2'h2

// ********************************************************************
// reset values
// ********************************************************************
`define GPC_FUNC_RESET 11'h000
`define GPC_DIR_RESET 11'h000
`define GPC_OUT_RESET 11'h000

// ********************************************************************
// timing
// ********************************************************************
`define GPC_CLK_PERIOD_NS 10
`define GPC_SAMPLE_MIN_NS 128
`define GPC_SAMPLE_CYC ((`GPC_SAMPLE_MIN_NS + `GPC_CLK_PERIOD_NS - 1) / `GPC_CLK_PERIOD_NS)

`endif

// ==== inc/gpc_pkg.sv ====
package gpc_pkg;

    // one configuration access aimed at the pin registers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [31:0] wdata;
    } gpc_cfg_req_t;

    // registered read answer
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } gpc_cfg_rsp_t;

    // per pin mode, one-hot
    typedef enum logic [2:0] {
        GPC_MODE_INPUT = 3'b001,
        GPC_MODE_OUTPUT = 3'b010,
        GPC_MODE_ALT = 3'b100
    } gpc_mode_t;

endpackage

// ==== hw/gpc_in_sampler.sv ====
`timescale 1ns/1ns
`include "gpc_defs.svh"

module gpc_in_sampler #(
    parameter int N = `GPC_NUM_PINS,
    parameter int SAMPLE_CYC = `GPC_SAMPLE_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] level_sync_out,
    output logic [N-1:0] level_sampled_out
);

    localparam int CW = $clog2(SAMPLE_CYC + 1);

    if (SAMPLE_CYC < 1) begin : g_bad_cyc
        $error("gpc_in_sampler: SAMPLE_CYC must be at least 1");
    end

    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] sampled_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire tick = (cnt_q == CW'(SAMPLE_CYC - 1));

    // pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign cnt_d = tick ? '0 : cnt_q + CW'(1);

    // capture no more often than once per sample interval
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= '0;
            sampled_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (tick) begin
                sampled_q <= sync_q; // (RULE7)
            end
        end
    end

    assign level_sync_out = sync_q;
    assign level_sampled_out = sampled_q;

endmodule // gpc_in_sampler

// ==== hw/gpc_pin_cell.sv ====
`timescale 1ns/1ns

module gpc_pin_cell (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic func_in,
    input wire logic dir_in,
    input wire logic out_val_in,
    input wire logic alt_val_in,
    input wire logic alt_drives_in,
    output logic pin_out,
    output logic pin_oe_out
);

    gpc_pkg::gpc_mode_t mode;
    logic drive_d;
    logic oe_d;

    // function bit wins over direction
    assign mode = func_in ? gpc_pkg::GPC_MODE_ALT :
                  (dir_in ? gpc_pkg::GPC_MODE_OUTPUT : gpc_pkg::GPC_MODE_INPUT); // (RULE10)

    always_comb begin
        drive_d = 1'b0;
        oe_d = 1'b0;
        unique case (mode)
            gpc_pkg::GPC_MODE_INPUT: begin
                drive_d = 1'b0;
                oe_d = 1'b0;
            end
            gpc_pkg::GPC_MODE_OUTPUT: begin
                drive_d = out_val_in; // (RULE13)
                oe_d = 1'b1;
            end
            gpc_pkg::GPC_MODE_ALT: begin
                drive_d = alt_val_in;
                oe_d = alt_drives_in;
            end
        endcase
    end

    // reset leaves the pin undriven, i.e. a plain input
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0; // (RULE6)
        end else begin
            pin_out <= drive_d;
            pin_oe_out <= oe_d;
        end
    end

endmodule // gpc_pin_cell

// ==== tb/gpc_board_model.sv ====
`timescale 1ns/1ns

// ********
// board side of the pins
// ********
module gpc_board_model #(
    parameter int N = 11
) (
    input wire logic [N-1:0] pin_drive_in,
    input wire logic [N-1:0] pin_oe_in,
    input wire logic [N-1:0] board_val_in,
    output logic [N-1:0] pin_level_out
);
    // a released pin shows the board level, so a missing drive reads as the board value
    assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & board_val_in);
endmodule // gpc_board_model

// ==== tb/gpc_gpio_chk.sv ====
`timescale 1ns/1ns
`include "gpc_defs.svh"

// ********
// port checks with a mirror of the written modes
// ********
module gpc_gpio_chk #(
    parameter int N = 11,
    parameter int SAMPLE_CYC = 13
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire gpc_pkg::gpc_cfg_req_t cfg_req_in,
    input wire gpc_pkg::gpc_cfg_rsp_t cfg_rsp_out,
    input wire logic [N-1:0] gpio_pin_in,
    input wire logic [N-1:0] gpio_pin_out,
    input wire logic [N-1:0] gpio_pin_oe_out,
    input wire logic [3:0] expander_irq_n_out
);
    logic [N-1:0] f_q, d_q, v_q;
    logic [2:0] st_q;
    wire logic wr_f = cfg_req_in.wr && cfg_req_in.sel == `GPC_SEL_FUNCTION;
    wire logic wr_d = cfg_req_in.wr && cfg_req_in.sel == `GPC_SEL_DIRECTION;
    wire logic wr_v = cfg_req_in.wr && cfg_req_in.sel == `GPC_SEL_DATA;
    wire logic [N-1:0] om = ~f_q & d_q;
    wire logic [N-1:0] eoe = om | (f_q & `GPC_ALT_OUTPUT_MASK);
    // st_q counts edges since a mode write, so irq checks skip the settling window
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            f_q <= '0;
            d_q <= '0;
            v_q <= '0;
            st_q <= '0;
        end else begin
            if (wr_f) f_q <= cfg_req_in.wdata[N-1:0] & `GPC_ALT_CAPABLE_MASK;
            if (wr_d) d_q <= cfg_req_in.wdata[N-1:0];
            if (wr_v) v_q <= cfg_req_in.wdata[N-1:0];
            if (wr_f || wr_d) st_q <= '0;
            else if (st_q != 3'h7) st_q <= st_q + 3'h1;
        end
    end

    // stab_q counts edges over which the pins have held still, saturating
    logic [N-1:0] pin_prev_q;
    int stab_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_prev_q <= '0;
            stab_q <= 0;
        end else begin
            pin_prev_q <= gpio_pin_in;
            if (gpio_pin_in != pin_prev_q) stab_q <= 0;
            else if (stab_q <= SAMPLE_CYC) stab_q <= stab_q + 1;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    chk_read_answer: assert property (cfg_req_in.rd |=> cfg_rsp_out.valid)
        else $error("read not answered next cycle");
    chk_valid_cause: assert property (cfg_rsp_out.valid |-> $past(cfg_req_in.rd))
        else $error("answer without read");
    chk_idle_zero: assert property (!cfg_rsp_out.valid |-> cfg_rsp_out.rdata == 32'h0000_0000)
        else $error("read data not zero while idle");
    chk_upper_zero: assert property (cfg_rsp_out.valid |-> cfg_rsp_out.rdata[31:N] == '0)
        else $error("upper read bits not zero");
    chk_unmapped_zero: assert property (cfg_req_in.rd && cfg_req_in.sel == 2'h3
        |=> cfg_rsp_out.rdata == 32'h0000_0000) else $error("unmapped read not zero");
    chk_reset_input: assert property ($rose(reset_n_in) |-> gpio_pin_oe_out == '0)
        else $error("pin driven after reset");
    chk_oe_decode: assert property (gpio_pin_oe_out == $past(eoe))
        else $error("drive enable does not match mode");
    chk_out_value: assert property (((gpio_pin_out ^ $past(v_q)) & $past(om)) == '0)
        else $error("output pin differs from stored data");
    chk_irq_route: assert property (st_q >= 3'h4 |-> expander_irq_n_out ==
        (~f_q[5:2] | $past(gpio_pin_in[5:2], 3))) else $error("expander irq misrouted");
    chk_level_read: assert property (cfg_req_in.rd && cfg_req_in.sel == `GPC_SEL_DATA
        && stab_q > SAMPLE_CYC |=> cfg_rsp_out.rdata[N-1:0] == $past(gpio_pin_in, 3))
        else $error("data read differs from steady pin level");
endmodule // gpc_gpio_chk

bind gpc_gpio_top gpc_gpio_chk #(.N(N), .SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk_sys_in,
    .reset_n_in, .cfg_req_in, .cfg_rsp_out, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_out,
    .expander_irq_n_out);

// ==== tb/gpio_pin_control_tb_top.sv ====
`timescale 1ns/1ns
`include "gpc_defs.svh"

// ********
// bench for the pin block
// ********
module gpio_pin_control_tb_top;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    gpc_pkg::gpc_cfg_req_t req = '0;
    gpc_pkg::gpc_cfg_rsp_t rsp;
    logic [10:0] board = 11'h000;
    logic [10:0] pin_lvl, pin_o, pin_oe, ealt;
    logic [4:0] ds_n = 5'h1F;
    logic ev_n = 1'b1;
    logic [3:0] irq_n;
    logic [31:0] rd_v;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    gpc_gpio_top dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cfg_req_in(req),
        .cfg_rsp_out(rsp), .gpio_pin_in(pin_lvl), .gpio_pin_out(pin_o),
        .gpio_pin_oe_out(pin_oe), .downstream1_reset_n_in(ds_n[0]),
        .downstream2_reset_n_in(ds_n[1]), .downstream3_reset_n_in(ds_n[2]),
        .downstream4_reset_n_in(ds_n[3]), .downstream5_reset_n_in(ds_n[4]),
        .general_event_n_in(ev_n), .expander_irq_n_out(irq_n));
    gpc_board_model brd (.pin_drive_in(pin_o), .pin_oe_in(pin_oe), .board_val_in(board),
        .pin_level_out(pin_lvl));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic cfg_wr(input logic [1:0] s, input logic [31:0] d);
        wait_n(1);
        req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
        wait_n(1);
        req.wr = 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [1:0] s, input logic [31:0] e);
        wait_n(1);
        req.rd = 1'b1;
        req.sel = s;
        wait_n(1);
        req.rd = 1'b0;
        check("read valid", 32'(rsp.valid), 32'h0000_0001);
        check(nm, rsp.rdata, e);
    endtask

    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        wait_n(5);
        reset_n_in = 1'b1;
        board = 11'h5A3;
        check("oe after reset", 32'(pin_oe), 32'h0000_0000);
        rdc("func reset", `GPC_SEL_FUNCTION, 32'h0000_0000);
        rdc("dir reset", `GPC_SEL_DIRECTION, 32'h0000_0000);
        wait_n(16);
        rdc("input level", `GPC_SEL_DATA, 32'h0000_05A3);
        rdc("unmapped", 2'h3, 32'h0000_0000);
        cfg_wr(`GPC_SEL_FUNCTION, 32'hFFFF_FFFF);
        rdc("func mask", `GPC_SEL_FUNCTION, 32'h0000_07BF);
        for (int k = 0; k < 2; k++) begin
            ds_n = k ? 5'h0A : 5'h15;
            ev_n = k[0];
            board = k ? 11'h014 : 11'h428;
            ealt = {ds_n[4], ds_n[2], ds_n[0], ev_n, 5'h00, ds_n[3], ds_n[1]};
            wait_n(5);
            check("alt oe", 32'(pin_oe), 32'h0000_0783);
            check("alt drive", 32'(pin_o & 11'h783), 32'(ealt));
            check("alt irq", 32'(irq_n), 32'(board[5:2]));
        end
        wait_n(16);
        rdc("alt level", `GPC_SEL_DATA, 32'(ealt | (board & 11'h07C)));
        ds_n = 5'h00;
        board = 11'h000;
        cfg_wr(`GPC_SEL_FUNCTION, 32'h0000_0000);
        wait_n(5);
        check("irq held off", 32'(irq_n), 32'h0000_000F);
        cfg_wr(`GPC_SEL_DATA, 32'h0000_0555);
        cfg_wr(`GPC_SEL_DIRECTION, 32'hFFFF_FFFF);
        rdc("dir mask", `GPC_SEL_DIRECTION, 32'h0000_07FF);
        check("out oe", 32'(pin_oe), 32'h0000_07FF);
        check("out value", 32'(pin_o), 32'h0000_0555);
        wait_n(16);
        rdc("out level", `GPC_SEL_DATA, 32'h0000_0555);
        cfg_wr(`GPC_SEL_DIRECTION, 32'h0000_0000);
        cfg_wr(`GPC_SEL_DATA, 32'h0000_02AA);
        check("input oe", 32'(pin_oe), 32'h0000_0000);
        cfg_wr(`GPC_SEL_DIRECTION, 32'h0000_07FF);
        wait_n(2);
        check("kept value", 32'(pin_o), 32'h0000_02AA);
        cfg_wr(`GPC_SEL_FUNCTION, 32'h0000_07FF);
        wait_n(2);
        check("alt over dir", 32'(pin_oe), 32'h0000_07C3);
        reset_n_in = 1'b0;
        wait_n(5);
        check("oe in reset", 32'(pin_oe), 32'h0000_0000);
        reset_n_in = 1'b1;
        rdc("dir after reset", `GPC_SEL_DIRECTION, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // gpio_pin_control_tb_top
